//--- design/aadc_datapath.sv
// adaptive asynchronous audio converter playback datapath, both channels
`timescale 1ns/1ps
`default_nettype none
module aadc_datapath #(
  parameter int SW         = 20,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // usb packet processor source
  input  wire logic                    usb_valid,
  output logic                         usb_ready,
  input  wire logic [SW-1:0]           usb_left,
  input  wire logic [SW-1:0]           usb_right,
  input  wire logic [1:0]              usb_bytes,
  input  wire logic                    usb_frame,
  // serial audio input source, already deserialised
  input  wire logic                    ser_valid,
  output logic                         ser_ready,
  input  wire logic [SW-1:0]           ser_left,
  input  wire logic [SW-1:0]           ser_right,
  input  wire logic                    src_serial,
  // sound features
  input  wire logic [5:0]              vol_left_att,
  input  wire logic [5:0]              vol_right_att,
  input  wire logic                    mute,
  input  wire logic [1:0]              treble,
  input  wire logic [1:0]              bass,
  input  wire logic                    bass_boost,
  // status
  output logic                         rate_locked,
  output aadc_pkg::aadc_domain_type    tone_domain,
  output logic                         frame_overrun,
  output logic                         fifo_underrun,
  // bitstream to semi_digital_stream_dac
  output logic                         bit_strobe,
  output logic                         bit_left,
  output logic                         bit_right
);
  import aadc_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int AC = SW + 8;

  // raised cosine, full scale 255, descending
  function automatic logic [7:0] ramp_coef(input logic [4:0] i);
    logic [7:0] t [32];
    t = '{8'hFF, 8'hFE, 8'hFB, 8'hF6, 8'hEF, 8'hE7, 8'hDD, 8'hD1,
          8'hC4, 8'hB6, 8'hA7, 8'h98, 8'h88, 8'h78, 8'h68, 8'h58,
          8'h49, 8'h3A, 8'h2C, 8'h1F, 8'h14, 8'h0B, 8'h05, 8'h01,
          8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    return t[i];
  endfunction : ramp_coef

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][2*SW-1:0] mem;
    logic [AW:0]              wp, rp;
    logic [1:0][2*SW-1:0]     skid;
    logic [1:0]               skid_n;
    logic [PER_W-1:0]         arr_cnt, per_est;
    logic                     locked;
    logic [PER_W+OSR_LOG-1:0] phase;
    logic [OSR_LOG-1:0]       sub;
    logic                     fs_stb;
    logic [1:0][SW-1:0]       cur;
    logic [1:0][SW-1:0]       feat;
    logic [1:0][SW-1:0]       up1, up2;
    logic [1:0][SW+1:0]       i1, i2, i3;
    logic [1:0]               bits;
    logic                     bstb;
    aadc_mute_type            mst;
    logic [4:0]               ridx, rhold;
    logic [1:0][SW-1:0]       bass_lp;
    logic [13:0]              fcnt;
    logic [8:0]               fbytes;
    logic                     ovr, und;
  } aadc_state_type;

  aadc_state_type st_reg, st_next;

  logic               in_valid, in_ready, fifo_full, fifo_empty;
  logic [2*SW-1:0]    in_word;
  logic [SW+1:0]      fb;

  always_comb begin
    in_valid  = src_serial ? ser_valid : usb_valid;
    in_word   = src_serial ? {ser_left, ser_right} : {usb_left, usb_right};
    in_ready  = (st_reg.skid_n != 2'd2);
    usb_ready = in_ready && !src_serial;
    ser_ready = in_ready && src_serial;
    fifo_full  = (st_reg.wp[AW] != st_reg.rp[AW]) && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
    fifo_empty = (st_reg.wp == st_reg.rp);
  end

  always_comb begin
    logic [SW+7:0] prod;
    logic [SW-1:0] s, hp;
    logic [SW+1:0] y;
    logic [5:0]    att;
    st_next = st_reg;
    prod = '0; s = '0; hp = '0; y = '0; att = '0; fb = '0;
    st_next.fs_stb = 1'b0;
    st_next.bstb   = 1'b0;
    // two-entry skid buffer ahead of the fifo keeps stalls lossless
    if (in_valid && in_ready) begin
      st_next.skid[st_reg.skid_n[0]] = in_word;
      st_next.skid_n = st_reg.skid_n + 2'd1;
    end
    if (st_reg.skid_n != 2'd0 && !fifo_full) begin
      st_next.mem[st_reg.wp[AW-1:0]] = st_reg.skid[0];
      st_next.wp = st_reg.wp + 1'b1;
      st_next.skid[0] = st_reg.skid[1];
      st_next.skid_n = st_next.skid_n - 2'd1;
      if (in_valid && in_ready) st_next.skid[st_reg.skid_n - 2'd1] = in_word;
      // rate recovery: smooth the arrival spacing
      if (st_reg.arr_cnt >= PER_W'(PER_MIN) && st_reg.arr_cnt <= PER_W'(PER_MAX)) begin
        st_next.per_est = st_reg.per_est - (st_reg.per_est >> PLL_SHIFT)
                          + (st_reg.arr_cnt >> PLL_SHIFT);
        st_next.locked = 1'b1;
      end
      st_next.arr_cnt = '0;
    end else if (st_reg.arr_cnt != {PER_W{1'b1}}) begin
      st_next.arr_cnt = st_reg.arr_cnt + 1'b1;
    end
    // frame byte budget
    st_next.fcnt = st_reg.fcnt + 14'd1;
    if (usb_frame || st_reg.fcnt == 14'(FRAME_CYCLES - 1)) begin
      st_next.fcnt = '0;
      st_next.fbytes = '0;
    end else if (usb_valid && usb_ready) begin
      st_next.fbytes = st_reg.fbytes + 9'((usb_bytes + 2'd1) * 2);
      if (st_next.fbytes > 9'(FRAME_BYTES_MAX)) st_next.ovr = 1'b1;
    end
    // 128fs strobe from recovered period; fs strobe every 128
    st_next.phase = st_reg.phase + (PER_W+OSR_LOG)'(OSR);
    if (st_reg.phase >= (PER_W+OSR_LOG)'(st_reg.per_est)) begin
      st_next.phase = st_reg.phase + (PER_W+OSR_LOG)'(OSR) - (PER_W+OSR_LOG)'(st_reg.per_est);
      st_next.bstb = st_reg.locked;
      st_next.sub = st_reg.sub + 1'b1;
      st_next.fs_stb = st_reg.locked && (st_reg.sub == '1);
    end
    if (st_reg.fs_stb) begin
      // read only at recovered timing; empty repeats last sample
      if (!fifo_empty) begin
        {st_next.cur[0], st_next.cur[1]} = st_reg.mem[st_reg.rp[AW-1:0]];
        st_next.rp = st_reg.rp + 1'b1;
        st_next.und = 1'b0;
      end else begin
        st_next.und = 1'b1;
      end
      // mute ramp stepping on whole samples
      unique case (st_reg.mst)
        AADC_MUTE_OPEN: if (mute) st_next.mst = AADC_MUTE_DOWN;
        AADC_MUTE_SHUT: if (!mute) st_next.mst = AADC_MUTE_UP;
        AADC_MUTE_DOWN, AADC_MUTE_UP: begin
          st_next.rhold = st_reg.rhold + 5'd1;
          if (st_reg.rhold == 5'(RAMP_HOLD - 1)) begin
            // index parks at the end entry so the table never wraps
            if (st_reg.mst == AADC_MUTE_DOWN) begin
              if (st_reg.ridx == 5'(RAMP_STEPS - 1)) st_next.mst = AADC_MUTE_SHUT;
              else st_next.ridx = st_reg.ridx + 5'd1;
            end else begin
              if (st_reg.ridx == 5'd0) st_next.mst = AADC_MUTE_OPEN;
              else st_next.ridx = st_reg.ridx - 5'd1;
            end
          end
        end
      endcase
      for (int c = 0; c < 2; c++) begin
        s = st_reg.cur[c];
        att = c == 0 ? vol_left_att : vol_right_att;
        s = (att > 6'd60) ? '0 : SW'($signed(s) >>> (att / 6));
        st_next.bass_lp[c] = SW'($signed(st_reg.bass_lp[c])
                             + (($signed(s) - $signed(st_reg.bass_lp[c])) >>> (3 + tone_domain)));
        hp = SW'($signed(s) - $signed(st_reg.bass_lp[c]));
        s = SW'($signed(s) + ($signed(hp) >>> (3 - treble))
                + ($signed(st_reg.bass_lp[c]) >>> (3 - bass))
                + (bass_boost ? ($signed(st_reg.bass_lp[c]) >>> 1) : SW'(0)));
        if (treble == 2'd0) s = SW'($signed(s) - ($signed(hp) >>> 3));
        if (bass == 2'd0) s = SW'($signed(s) - ($signed(st_reg.bass_lp[c]) >>> 3));
        prod = SW'($signed(s)) * $signed({1'b0, ramp_coef(st_reg.ridx)});
        st_next.feat[c] = prod[SW+7:8];
      end
    end
    if (st_reg.bstb) begin
      for (int c = 0; c < 2; c++) begin
        // two averaging upsample stages, held between strobes
        st_next.up1[c] = SW'(($signed(st_reg.up1[c]) + $signed(st_reg.feat[c])) >>> 1);
        st_next.up2[c] = SW'(($signed(st_reg.up2[c]) + $signed(st_reg.up1[c])) >>> 1);
        fb = st_reg.bits[c] ? (SW+2)'(1 << (SW-1)) : -(SW+2)'(1 << (SW-1));
        st_next.i1[c] = st_reg.i1[c] + {{2{st_reg.up2[c][SW-1]}}, st_reg.up2[c]} - fb;
        st_next.i2[c] = st_reg.i2[c] + st_reg.i1[c] - fb;
        st_next.i3[c] = st_reg.i3[c] + st_reg.i2[c] - fb;
        y = st_reg.i3[c] + (st_reg.i2[c] >>> 1);
        st_next.bits[c] = !y[SW+1];
      end
    end
    if (sys_rst) begin
      st_next = '0;
      st_next.per_est = PER_W'(PER_MAX);
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  always_comb begin
    if (st_reg.per_est > PER_W'(PER_DOM1)) tone_domain = AADC_DOM_LOW;
    else if (st_reg.per_est > PER_W'(PER_DOM2)) tone_domain = AADC_DOM_MIDLOW;
    else if (st_reg.per_est > PER_W'(PER_DOM3)) tone_domain = AADC_DOM_MIDHIGH;
    else tone_domain = AADC_DOM_HIGH;
  end

  assign rate_locked   = st_reg.locked;
  assign frame_overrun = st_reg.ovr;
  assign fifo_underrun = st_reg.und;
  assign bit_strobe    = st_reg.bstb;
  assign bit_left      = st_reg.bits[0];
  assign bit_right     = st_reg.bits[1];
endmodule : aadc_datapath
`default_nettype wire

//--- design/aadc_pkg.sv
// constants and types shared by the adaptive audio converter datapath
// Function
// - accept samples from USB or serial input
// - digital loop recovers sample rate, makes strobes
// - fifo read at recovered rate removes jitter
// - tone domain auto-chosen at 12/25/40 kHz
// - continuous input rate from 5 to 55 kHz
// - two upsamplers plus hold reach 128fs
// - third-order noise shaper pushes noise out-of-band
// - shaper output is one bit per channel
// - more than 336 audio bytes per frame sets a sticky overrun flag
// - volume, mute, treble, bass, bass boost applied
// - mute ramps 32 coefficients, 32 samples each
package aadc_pkg;
  localparam int CLK_HZ           = 10_000_000;
  localparam int FS_MIN_HZ        = 5_000;
  localparam int FS_MAX_HZ        = 55_000;
  localparam int DOM1_TOP_HZ      = 12_000;
  localparam int DOM2_TOP_HZ      = 25_000;
  localparam int DOM3_TOP_HZ      = 40_000;
  // sample period in clocks at each boundary
  localparam int PER_MAX          = CLK_HZ / FS_MIN_HZ;
  localparam int PER_MIN          = CLK_HZ / FS_MAX_HZ;
  localparam int PER_DOM1         = CLK_HZ / DOM1_TOP_HZ;
  localparam int PER_DOM2         = CLK_HZ / DOM2_TOP_HZ;
  localparam int PER_DOM3         = CLK_HZ / DOM3_TOP_HZ;
  localparam int OSR              = 128;
  localparam int OSR_LOG          = 7;
  localparam int FRAME_BYTES_MAX  = 336;
  localparam int FRAME_MS         = 1;
  localparam int FRAME_CYCLES     = CLK_HZ / 1000 * FRAME_MS;
  localparam int RAMP_STEPS       = 32;
  localparam int RAMP_HOLD        = 32;
  localparam int PER_W            = 12;
  localparam int PLL_SHIFT        = 3;
  typedef enum logic [1:0] {
    AADC_DOM_LOW, AADC_DOM_MIDLOW, AADC_DOM_MIDHIGH, AADC_DOM_HIGH
  } aadc_domain_type;
  typedef enum logic [1:0] {
    AADC_MUTE_OPEN, AADC_MUTE_DOWN, AADC_MUTE_SHUT, AADC_MUTE_UP
  } aadc_mute_type;
endpackage : aadc_pkg

//--- verification/aadc_datapath_asserts.sv
// port assertions for the converter datapath
`timescale 1ns/1ps
`default_nettype none
module aadc_datapath_asserts (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      sys_rst,
  // sources
  input wire logic                      usb_valid,
  input wire logic                      usb_ready,
  input wire logic                      ser_valid,
  input wire logic                      ser_ready,
  input wire logic                      src_serial,
  // status and bitstream
  input wire logic                      rate_locked,
  input wire aadc_pkg::aadc_domain_type tone_domain,
  input wire logic                      frame_overrun,
  input wire logic                      fifo_underrun,
  input wire logic                      bit_strobe,
  input wire logic                      bit_left,
  input wire logic                      bit_right
);
  import aadc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_usb_idle; usb_ready && !usb_valid && !src_serial; endsequence
  sequence s_ser_idle; ser_ready && !ser_valid && src_serial; endsequence
  a_usb_unselected: assert property (src_serial |-> !usb_ready)
    else $error("usb ready while serial selected");
  a_ser_unselected: assert property (!src_serial |-> !ser_ready)
    else $error("serial ready while usb selected");
  a_usb_ready_hold: assert property (s_usb_idle ##1 !src_serial |-> usb_ready)
    else $error("usb ready dropped with nothing taken");
  a_ser_ready_hold: assert property (s_ser_idle ##1 src_serial |-> ser_ready)
    else $error("serial ready dropped with nothing taken");
  a_bits_on_strobe: assert property (!bit_strobe && !$past(bit_strobe) |-> $stable({bit_left, bit_right}))
    else $error("bitstream moved without strobe");
  a_strobe_rate: assert property (rate_locked |-> ##[0:20] bit_strobe)
    else $error("bit strobe missing while locked");
  a_overrun_sticky: assert property (frame_overrun |=> frame_overrun)
    else $error("overrun flag cleared without reset");
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> !frame_overrun && !fifo_underrun
    && !rate_locked && !bit_strobe && tone_domain == AADC_DOM_LOW) else $error("status not cleared by reset");
endmodule : aadc_datapath_asserts
`default_nettype wire

//--- verification/aadc_datapath_tb.sv
// self-checking bench for the converter datapath
`timescale 1ns/1ps
`default_nettype none
module aadc_datapath_tb;
  import aadc_pkg::*;
  logic clk, sys_rst, run, greedy, usb_valid, usb_ready, usb_frame, ser_valid, ser_ready, src_serial, mute;
  logic bass_boost, rate_locked, frame_overrun, fifo_underrun, bit_strobe, bit_left, bit_right;
  logic [19:0] usb_left, usb_right, ser_left, ser_right;
  logic [11:0] gap;
  logic [5:0] vol_att;
  logic [1:0] usb_bytes, treble, bass;
  aadc_domain_type tone_domain;
  int errors, comparisons, sent;
  always #50 clk = ~clk;
  aadc_usb_source aadc_usb_source_inst (.clk(clk), .sys_rst(sys_rst), .run(run), .greedy(greedy), .gap(gap),
    .usb_valid(usb_valid), .usb_ready(usb_ready), .usb_left(usb_left), .usb_right(usb_right),
    .usb_frame(usb_frame), .sent(sent));
  // deep buffer so a flood beats any frame window phase
  aadc_datapath #(.FIFO_DEPTH(128)) aadc_datapath_inst (.clk(clk), .sys_rst(sys_rst), .usb_valid(usb_valid),
    .usb_ready(usb_ready), .usb_left(usb_left), .usb_right(usb_right), .usb_bytes(usb_bytes),
    .usb_frame(usb_frame), .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_left(ser_left),
    .ser_right(ser_right), .src_serial(src_serial), .vol_left_att(vol_att), .vol_right_att(vol_att ^ 6'h01),
    .mute(mute), .treble(treble), .bass(bass), .bass_boost(bass_boost), .rate_locked(rate_locked),
    .tone_domain(tone_domain), .frame_overrun(frame_overrun), .fifo_underrun(fifo_underrun),
    .bit_strobe(bit_strobe), .bit_left(bit_left), .bit_right(bit_right));
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic wait_sent(input int n);
    int target;
    target = sent + n;
    for (int i = 0; i < n * 4000 && sent < target; i++) @(negedge clk);
    check_eq(sent >= target, 1);
    if (sent < target) stop_test();
  endtask : wait_sent
  task automatic t_domains();
    int gaps[4] = '{1000, 500, 300, 200};
    int n, ones;
    for (int i = 0; i < 4; i++) begin
      gap = 12'(gaps[i]);
      treble = 2'(i);
      bass = 2'(3 - i);
      bass_boost = i[0];
      vol_att = 6'(i * 20);
      wait_sent(24);
      check_eq(rate_locked, 1);
      check_eq(tone_domain, 32'(i));
    end
    n = 0;
    ones = 0;
    for (int k = 0; k < 2010; k++) begin
      @(posedge clk);
      #1;
      n += int'(bit_strobe === 1'b1);
      ones += int'(bit_strobe === 1'b1 && bit_left === 1'b1);
    end
    check_eq(n >= 1216 && n <= 1344, 1);
    check_eq(ones > 0 && ones < n, 1);
    check_eq(frame_overrun, 0);
  endtask : t_domains
  // ready is judged at the falling edge, so the pair stands over the taking edge
  task automatic send_serial(input logic [19:0] l, input logic [19:0] r);
    int w;
    ser_left = l;
    ser_right = r;
    ser_valid = 1'b1;
    w = 0;
    while (ser_ready !== 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    check_eq(w < 400, 1);
    if (w >= 400) stop_test();
    @(negedge clk);
    ser_valid = 1'b0;
    ser_left = ~ser_left;
    ser_right = ~ser_right;
  endtask : send_serial
  task automatic t_serial();
    run = 1'b0;
    src_serial = 1'b1;
    @(negedge clk);
    check_eq(usb_ready, 0);
    for (int k = 0; k < 30; k++) begin
      send_serial(20'(k * 4099), ~20'(k * 4099));
      repeat (199) @(negedge clk);
    end
    check_eq(fifo_underrun, 0);
    src_serial = 1'b0;
  endtask : t_serial
  // equal pairs from a clean reset must give equal bitstreams
  task automatic t_lockstep();
    int n;
    src_serial = 1'b1;
    vol_att = 6'h00;
    n = 0;
    for (int k = 0; k < 24; k++) begin
      mute = (k >= 12);
      send_serial(20'(k * 9001), 20'(k * 9001));
      for (int j = 0; j < 199; j++) begin
        @(posedge clk);
        #1;
        if (bit_strobe === 1'b1) begin
          n++;
          check_eq(bit_left, bit_right);
        end
      end
      @(negedge clk);
    end
    check_eq(n > 0, 1);
  endtask : t_lockstep
  task automatic t_starve_flood();
    for (int k = 0; k < 20000 && fifo_underrun !== 1'b1; k++) @(negedge clk);
    check_eq(fifo_underrun, 1);
    greedy = 1'b1;
    gap = 12'h001;
    run = 1'b1;
    for (int k = 0; k < 12000 && frame_overrun !== 1'b1; k++) @(negedge clk);
    check_eq(frame_overrun, 1);
    // underrun only clears at the next sample-rate read
    for (int k = 0; k < 2 * PER_MAX && fifo_underrun !== 1'b0; k++) @(negedge clk);
    check_eq(fifo_underrun, 0);
    run = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    check_eq(frame_overrun, 0);
    check_eq(tone_domain, AADC_DOM_LOW);
  endtask : t_starve_flood
  initial begin
    {clk, run, greedy, ser_valid, src_serial, mute, bass_boost} = '0;
    {ser_left, ser_right, gap, vol_att, treble, bass} = '0;
    sys_rst = 1'b1;
    usb_bytes = 2'h2;
    errors = 0;
    comparisons = 0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    check_eq(usb_ready, 1);
    check_eq(ser_ready, 0);
    run = 1'b1;
    t_domains();
    t_serial();
    t_starve_flood();
    t_lockstep();
    stop_test();
  end
endmodule : aadc_datapath_tb
bind aadc_datapath aadc_datapath_asserts aadc_datapath_asserts_inst (.clk(clk), .sys_rst(sys_rst),
  .usb_valid(usb_valid), .usb_ready(usb_ready), .ser_valid(ser_valid), .ser_ready(ser_ready),
  .src_serial(src_serial), .rate_locked(rate_locked), .tone_domain(tone_domain), .frame_overrun(frame_overrun),
  .fifo_underrun(fifo_underrun), .bit_strobe(bit_strobe), .bit_left(bit_left), .bit_right(bit_right));
`default_nettype wire

//--- verification/aadc_usb_source.sv
// model of the usb packet processor offering sample pairs
`timescale 1ns/1ps
`default_nettype none
module aadc_usb_source (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // pacing
  input  wire logic        run,
  input  wire logic        greedy,
  input  wire logic [11:0] gap,
  // sample stream
  output logic             usb_valid,
  input  wire logic        usb_ready,
  output logic [19:0]      usb_left,
  output logic [19:0]      usb_right,
  output logic             usb_frame,
  output int               sent
);
  import aadc_pkg::*;
  int   fcnt, infr, idle;
  logic taken;
  always @(posedge clk) taken <= usb_valid && usb_ready;
  always @(negedge clk) begin
    if (sys_rst) begin
      usb_valid = 1'b0;
      usb_frame = 1'b0;
      fcnt = 0;
      infr = 0;
      idle = 0;
      sent = 0;
    end else begin
      usb_frame = (fcnt == FRAME_CYCLES - 1);
      fcnt = usb_frame ? 0 : fcnt + 1;
      if (usb_frame) infr = 0;
      if (taken) begin
        usb_valid = 1'b0;
        sent++;
        infr++;
        idle = 0;
      end
      idle++;
      // greedy breaks the per-frame byte budget on purpose
      if (!usb_valid && !taken && run && idle >= gap && (greedy || infr * 6 < FRAME_BYTES_MAX)) begin
        usb_valid = 1'b1;
        usb_left = 20'(sent * 2731);
        usb_right = ~usb_left;
      end else if (!usb_valid) begin
        // released lines alternate each cycle between the last word and its inverse
        usb_left = ~usb_left;
        usb_right = ~usb_right;
      end
    end
  end
endmodule : aadc_usb_source
`default_nettype wire
